// [src/chan_reg_mem.sv]
`timescale 1ns/100ps
// small register store, one write port, registered read port
module chan_reg_mem import dac_ctrl_pkg::*; #(
  parameter int WIDTH = 14,
  parameter int AW = 6
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1]; // contents set by the reset walk, not by reset
  logic [WIDTH-1:0] rdata_reg; // read data register

  // write port
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// [src/dac_channel_update_control.sv]
`timescale 1ns/100ps
// Overview of operation
// - address pins pick one of 40 channels
// - select pins pick data, offset, gain, special
// - serial out tristates, shifts on rising clock
// - serial out feeds next device in chain
// - bank pin picks A or B in toggle
// - each load in toggle mode swaps outputs between A and B
// - without toggle mode all data goes to A
// - busy low during code calculation
// - writes accepted during calc, no DAC update
// - load strobe fall while idle updates DACs
// - load strobe during calc stored, done later
// - power-on reset: busy low, strobes discarded
// - clear edge loads clear code, busy 35 us
// - reset edge restores defaults, busy 270 us
// - reset sequence disables interface, ignores loads
// - after reset only a new edge counts
// - power-down input enters hiz or load, control bit picks which
// - serial interface stays alive in power-down
// - write on strobe rising edge, chip select low
module dac_channel_update_control import dac_ctrl_pkg::*; #(
  parameter logic [CNT_W-1:0] CALC_CYCLES = 12'h030
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic interface_select_i,
  input wire logic [ADDR_W-1:0] channel_address_inputs_i,
  input wire logic [SEL_W-1:0] register_select_pins_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic chip_select_n_i,
  input wire logic write_n_i,
  input wire logic bank_select_i,
  input wire logic load_outputs_strobe_n_i,
  input wire logic clear_input_n_i,
  input wire logic reset_pin_n_i,
  input wire logic power_down_input_i,
  input wire logic serial_clk_i,
  input wire logic serial_sync_n_i,
  input wire logic serial_data_i,
  input wire logic [DAC_AW-1:0] dac_read_addr_i,
  output logic busy_o,
  output logic [DATA_W-1:0] dac_code_o,
  output logic power_down_active_o,
  output logic output_hiz_o,
  output logic output_load_o,
  output logic toggle_mode_o,
  output logic serial_data_o,
  output logic serial_data_oe_n_o
);
  // sequencer state
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [CNT_W-1:0] cnt_reg; // cycles spent in the current state
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] dur; // length of the current state
  logic cnt_done;

  // edge detectors on the strobe pins
  logic load_outputs_strobe_prev_reg;
  logic clr_prev_reg;
  logic rst_pin_prev_reg;
  logic wr_prev_reg;
  logic load_outputs_strobe_fall;
  logic clear_fall;
  logic reset_fall;
  logic wr_rise;

  // control and status
  logic busy_reg;
  logic pend_reg; // stored load request
  logic pend_next;
  logic toggle_bank_reg; // bank currently on the outputs
  logic toggle_bank_next;
  logic toggle_mode_reg;
  logic pd_option_reg; // 1: 100k load, 0: high impedance
  logic [DATA_W-1:0] clear_code_reg;
  logic pd_active_reg;
  logic output_hiz_reg;
  logic output_load_reg;

  // decode wires
  logic in_reset;
  logic wr_take;
  logic ch_ok;
  logic is_special;
  logic bus_in_we;
  logic [SEL_W-1:0] bus_slot;
  logic sf_clear_we;
  logic sf_ctrl_we;
  logic load_go;
  logic pend_set;

  // store access wires
  logic rst_walk_in;
  logic in_we;
  logic [IN_AW-1:0] in_waddr;
  logic [DATA_W-1:0] in_wdata;
  logic [DATA_W-1:0] rst_default;
  logic [IN_AW-1:0] in_raddr;
  logic [DATA_W-1:0] calculated_dac_word;
  logic walk_bank;
  logic load_wr;
  logic clr_wr;
  logic rst_wr;
  logic dac_we;
  logic [DAC_AW-1:0] dac_waddr;
  logic [DATA_W-1:0] dac_wdata;
  logic serial_enable;

  // strobe edges; pins are already synchronous to the core clock
  assign load_outputs_strobe_fall = load_outputs_strobe_prev_reg & ~load_outputs_strobe_n_i;
  assign clear_fall = clr_prev_reg & ~clear_input_n_i;
  assign reset_fall = rst_pin_prev_reg & ~reset_pin_n_i;
  assign wr_rise = ~wr_prev_reg & write_n_i;

  // interface gating while the reset sequence runs
  assign in_reset = (state_reg == ST_RESET) | reset_fall;

  // parallel write decode
  assign wr_take = wr_rise & ~chip_select_n_i & ~interface_select_i & ~in_reset;
  assign ch_ok = channel_address_inputs_i < NUM_CH_ADDR;
  assign is_special = register_select_pins_i == REG_SEL_SPECIAL;
  assign bus_in_we = wr_take & ~is_special & ch_ok;
  // data writes go to A unless toggle mode lets the bank pin choose
  assign bus_slot = (register_select_pins_i == REG_SEL_DATA) ?
                    {1'b0, toggle_mode_reg & bank_select_i} :
                    (register_select_pins_i == REG_SEL_OFFSET) ? SLOT_OFFSET :
                    SLOT_GAIN;
  assign sf_clear_we = wr_take & is_special &
                       (channel_address_inputs_i == SF_CLEAR_CODE_ADDR);
  assign sf_ctrl_we = wr_take & is_special &
                      (channel_address_inputs_i == SF_CONTROL_ADDR);

  // load request handling
  assign load_go = (state_reg == ST_IDLE) & ~reset_fall & ~clear_fall &
                   (load_outputs_strobe_fall | pend_reg);
  assign pend_set = load_outputs_strobe_fall & ~in_reset & ~load_go;
  // a strobe in the same cycle as a serviced request is merged into it and not kept
  assign pend_next = in_reset ? 1'b0 :
                     pend_set ? 1'b1 :
                     load_go ? 1'b0 : pend_reg;
  assign toggle_bank_next = in_reset ? 1'b0 :
                            (load_go & toggle_mode_reg) ? ~toggle_bank_reg :
                            toggle_bank_reg;

  // length of each busy state
  assign dur = (state_reg == ST_CALC) ? CALC_CYCLES :
               (state_reg == ST_LOAD) ? LOAD_CYCLES :
               (state_reg == ST_CLEAR) ? CLEAR_CYCLES : RESET_CYCLES;
  assign cnt_done = cnt_reg == CNT_W'(dur - 1'b1);

  // next-state logic; reset edge first, clear next, then loads, writes last
  always_comb begin
    state_next = state_reg;
    cnt_next = CNT_W'(cnt_reg + 1'b1);
    if (reset_fall) begin
      state_next = ST_RESET;
      cnt_next = '0;
    end else if (state_reg == ST_RESET) begin
      // clear and load edges are dropped here
      if (cnt_done) begin
        state_next = ST_IDLE;
        cnt_next = '0;
      end
    end else if (clear_fall) begin
      state_next = ST_CLEAR;
      cnt_next = '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cnt_next = '0;
          if (load_go) begin
            state_next = ST_LOAD;
          end else if (bus_in_we) begin
            state_next = ST_CALC;
          end
        end
        ST_CALC, ST_LOAD, ST_CLEAR: begin
          // writes keep landing, they do not restart the count
          if (cnt_done) begin
            state_next = ST_IDLE;
            cnt_next = '0;
          end
        end
        default: begin
          state_next = ST_IDLE;
          cnt_next = '0;
        end
      endcase
    end
  end

  // input store: reset walk writes defaults, else the parallel bus
  assign rst_walk_in = (state_reg == ST_RESET) && (cnt_reg[CNT_W-1:IN_AW] == '0);
  assign rst_default = (cnt_reg[IN_AW-1:DAC_AW] == SLOT_OFFSET) ? OFFSET_DEFAULT :
                       (cnt_reg[IN_AW-1:DAC_AW] == SLOT_GAIN) ? GAIN_DEFAULT :
                       INPUT_DEFAULT;
  assign in_we = rst_walk_in | bus_in_we;
  assign in_waddr = rst_walk_in ? cnt_reg[IN_AW-1:0] :
                    {bus_slot, channel_address_inputs_i};
  assign in_wdata = rst_walk_in ? rst_default : data_i;
  assign walk_bank = toggle_mode_reg ? toggle_bank_reg : 1'b0;
  assign in_raddr = {1'b0, walk_bank, cnt_reg[DAC_AW-1:0]};

  // dac store writes: load copy, clear code, reset defaults
  assign load_wr = (state_reg == ST_LOAD) && (cnt_reg != '0);
  assign clr_wr = (state_reg == ST_CLEAR) && (cnt_reg < CNT_W'(NUM_CH));
  assign rst_wr = (state_reg == ST_RESET) && (cnt_reg[CNT_W-1:DAC_AW] == '0);
  assign dac_we = load_wr | clr_wr | rst_wr;
  assign dac_waddr = load_wr ? DAC_AW'(cnt_reg - 1'b1) : cnt_reg[DAC_AW-1:0];
  assign dac_wdata = load_wr ? calculated_dac_word :
                     clr_wr ? clear_code_reg : DAC_DEFAULT;

  // serial side runs regardless of power-down
  assign serial_enable = interface_select_i & ~in_reset;

  // strobe history
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_outputs_strobe_prev_reg <= 1'b1;
      clr_prev_reg <= 1'b1;
      rst_pin_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end else begin
      load_outputs_strobe_prev_reg <= load_outputs_strobe_n_i;
      clr_prev_reg <= clear_input_n_i;
      rst_pin_prev_reg <= reset_pin_n_i;
      wr_prev_reg <= write_n_i;
    end
  end

  // sequencer; power-on starts the same walk as the reset pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_RESET;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= state_next == ST_IDLE;
    end
  end

  // load request and toggle bank
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_reg <= 1'b0;
      toggle_bank_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      toggle_bank_reg <= toggle_bank_next;
    end
  end

  // special function registers, restored by the reset walk
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clear_code_reg <= CLEAR_CODE_DEFAULT;
      toggle_mode_reg <= 1'b0;
      pd_option_reg <= 1'b0;
    end else if (in_reset) begin
      clear_code_reg <= CLEAR_CODE_DEFAULT;
      toggle_mode_reg <= 1'b0;
      pd_option_reg <= 1'b0;
    end else begin
      if (sf_clear_we) begin
        clear_code_reg <= data_i;
      end
      if (sf_ctrl_we) begin
        toggle_mode_reg <= data_i[CTRL_TOGGLE_BIT];
        pd_option_reg <= data_i[CTRL_PD_LOAD_BIT];
      end
    end
  end

  // power-down output stage controls
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pd_active_reg <= 1'b0;
      output_hiz_reg <= 1'b0;
      output_load_reg <= 1'b0;
    end else begin
      pd_active_reg <= power_down_input_i;
      output_hiz_reg <= power_down_input_i & ~pd_option_reg;
      output_load_reg <= power_down_input_i & pd_option_reg;
    end
  end

  // input code store: A, B, offset and gain per channel
  chan_reg_mem #(.WIDTH(DATA_W), .AW(IN_AW)) input_code_register_mem (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .we_i(in_we),
    .waddr_i(in_waddr),
    .wdata_i(in_wdata),
    .raddr_i(in_raddr),
    .rdata_o(calculated_dac_word)
  );

  // dac code store; read port faces the output stage
  chan_reg_mem #(.WIDTH(DATA_W), .AW(DAC_AW)) dac_code_mem (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .we_i(dac_we),
    .waddr_i(dac_waddr),
    .wdata_i(dac_wdata),
    .raddr_i(dac_read_addr_i),
    .rdata_o(dac_code_o)
  );

  // serial chain output
  serial_link_shifter serial_link (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(serial_enable),
    .serial_clk_i(serial_clk_i),
    .serial_sync_n_i(serial_sync_n_i),
    .serial_data_i(serial_data_i),
    .serial_data_o(serial_data_o),
    .serial_data_oe_n_o(serial_data_oe_n_o)
  );

  assign busy_o = busy_reg;
  assign power_down_active_o = pd_active_reg;
  assign output_hiz_o = output_hiz_reg;
  assign output_load_o = output_load_reg;
  assign toggle_mode_o = toggle_mode_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_reset_busy;
    reset_fall |=> (!busy_o) [*8];
  endproperty
  a_reset_busy: assert property (p_reset_busy)
    else $error("busy not held low after reset edge");

  property p_clear_busy;
    (clear_fall && state_reg != ST_RESET && !reset_fall) |=> (!busy_o) [*8];
  endproperty
  a_clear_busy: assert property (p_clear_busy)
    else $error("busy not held low after clear edge");

  property p_reset_drops_load;
    (state_reg == ST_RESET) |=> !pend_reg;
  endproperty
  a_reset_drops_load: assert property (p_reset_drops_load)
    else $error("load request kept during reset sequence");

  property p_load_stored;
    (load_outputs_strobe_fall && !reset_fall && (state_reg == ST_CALC || state_reg == ST_LOAD ||
     state_reg == ST_CLEAR)) |=> pend_reg;
  endproperty
  a_load_stored: assert property (p_load_stored)
    else $error("load strobe during busy was lost");

  property p_load_idle;
    (load_outputs_strobe_fall && state_reg == ST_IDLE && !reset_fall && !clear_fall)
      |=> (state_reg == ST_LOAD) && !busy_o;
  endproperty
  a_load_idle: assert property (p_load_idle)
    else $error("load strobe while idle did not start an update");

  property p_pend_serviced;
    (pend_reg && state_reg == ST_IDLE && !reset_fall && !clear_fall && !load_outputs_strobe_fall)
      |=> (state_reg == ST_LOAD) && !pend_reg;
  endproperty
  a_pend_serviced: assert property (p_pend_serviced)
    else $error("stored load not serviced or not cleared");

  property p_calc_no_update;
    (state_reg == ST_CALC) |-> !dac_we;
  endproperty
  a_calc_no_update: assert property (p_calc_no_update)
    else $error("dac store written during calculation");

  property p_write_busy;
    (bus_in_we && state_reg == ST_IDLE && !load_outputs_strobe_fall && !pend_reg && !clear_fall)
      |=> !busy_o;
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("busy not low after an input write");

  property p_bad_channel;
    (wr_take && !is_special && channel_address_inputs_i >= NUM_CH_ADDR) |-> !in_we;
  endproperty
  a_bad_channel: assert property (p_bad_channel)
    else $error("write to channel beyond the last one");

  property p_toggle_swap;
    (load_go && toggle_mode_reg) |=> toggle_bank_reg != $past(toggle_bank_reg);
  endproperty
  a_toggle_swap: assert property (p_toggle_swap)
    else $error("toggle bank did not swap on load");

  property p_pd_follow;
    power_down_input_i |=> power_down_active_o && (output_hiz_o != output_load_o);
  endproperty
  a_pd_follow: assert property (p_pd_follow)
    else $error("power-down output stage not set");
endmodule

// [src/dac_ctrl_pkg.sv]
package dac_ctrl_pkg;
  // channel and word geometry
  localparam int NUM_CH = 40;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 14;
  localparam int SEL_W = 2;
  localparam int IN_AW = 8;
  localparam int DAC_AW = 6;
  localparam int CNT_W = 12;
  localparam int SR_W = 24;
  localparam logic [ADDR_W-1:0] NUM_CH_ADDR = 6'h28;
  // register-select pin codes
  localparam logic [SEL_W-1:0] REG_SEL_SPECIAL = 2'h0;
  localparam logic [SEL_W-1:0] REG_SEL_GAIN = 2'h1;
  localparam logic [SEL_W-1:0] REG_SEL_OFFSET = 2'h2;
  localparam logic [SEL_W-1:0] REG_SEL_DATA = 2'h3;
  // storage slots of the input store (upper address bits)
  localparam logic [SEL_W-1:0] SLOT_A = 2'h0;
  localparam logic [SEL_W-1:0] SLOT_OFFSET = 2'h2;
  localparam logic [SEL_W-1:0] SLOT_GAIN = 2'h3;
  // special function register addresses
  localparam logic [ADDR_W-1:0] SF_CLEAR_CODE_ADDR = 6'h02;
  localparam logic [ADDR_W-1:0] SF_CONTROL_ADDR = 6'h0C;
  localparam int CTRL_TOGGLE_BIT = 0;
  localparam int CTRL_PD_LOAD_BIT = 1;
  // power-on defaults
  localparam logic [DATA_W-1:0] INPUT_DEFAULT = 14'h0000;
  localparam logic [DATA_W-1:0] OFFSET_DEFAULT = 14'h2000;
  localparam logic [DATA_W-1:0] GAIN_DEFAULT = 14'h3FFF;
  localparam logic [DATA_W-1:0] DAC_DEFAULT = 14'h0000;
  localparam logic [DATA_W-1:0] CLEAR_CODE_DEFAULT = 14'h2000;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLEAR_TIME_NS = 35000;
  localparam int RESET_TIME_NS = 270000;
  localparam logic [CNT_W-1:0] CLEAR_CYCLES =
    CNT_W'((CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_CYCLES =
    CNT_W'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LOAD_CYCLES = CNT_W'(NUM_CH + 1);
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_CALC, ST_LOAD, ST_CLEAR, ST_RESET} seq_state_t;
endpackage

// [src/serial_link_shifter.sv]
`timescale 1ns/100ps
// daisy-chain shifter behind the serial data output
module serial_link_shifter import dac_ctrl_pkg::*; (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic serial_clk_i,
  input wire logic serial_sync_n_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_n_o
);
  logic sclk_prev_reg; // last sampled serial clock
  logic [SR_W-1:0] shift_reg; // chain shift register
  logic sdo_reg; // output bit
  logic oe_n_reg; // output enable, low drives
  logic framed; // frame open and mode active
  logic sclk_rise;
  logic sclk_fall;

  assign framed = enable_i & ~serial_sync_n_i;
  assign sclk_rise = serial_clk_i & ~sclk_prev_reg;
  assign sclk_fall = ~serial_clk_i & sclk_prev_reg;

  // shift in on falling edge, present msb on rising edge
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_prev_reg <= 1'b0;
      shift_reg <= '0;
      sdo_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= serial_clk_i;
      oe_n_reg <= ~framed;
      if (framed && sclk_fall) begin
        shift_reg <= {shift_reg[SR_W-2:0], serial_data_i};
      end
      if (framed && sclk_rise) begin
        sdo_reg <= shift_reg[SR_W-1];
      end
    end
  end

  assign serial_data_o = sdo_reg;
  assign serial_data_oe_n_o = oe_n_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_sdo_hiz_outside_frame;
    !framed |=> serial_data_oe_n_o;
  endproperty
  a_sdo_hiz_outside_frame: assert property (p_sdo_hiz_outside_frame)
    else $error("serial output driven outside a frame");

  property p_sdo_rise_only;
    (framed && !sclk_rise) |=> $stable(serial_data_o);
  endproperty
  a_sdo_rise_only: assert property (p_sdo_rise_only)
    else $error("serial output moved without a rising serial clock");
endmodule

// [verification/dac_channel_update_control_tb.sv]
`timescale 1ns/100ps
module dac_channel_update_control_tb import dac_ctrl_pkg::*; ;
  localparam logic [CNT_W-1:0] CALC = 12'h004; // short calc keeps the run brief
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [SEL_W-1:0] s;
    logic [DATA_W-1:0] d;
    logic [DAC_AW-1:0] r;
    logic [DATA_W-1:0] e;
  } row_t;
  // write, load, then read back; offset/gain leave the code alone, ch 40 refused
  row_t rows [5] = '{'{6'h00, REG_SEL_DATA, 14'h1234, 6'h00, 14'h1234},
    '{6'h27, REG_SEL_DATA, 14'h2ABC, 6'h27, 14'h2ABC},
    '{6'h05, REG_SEL_OFFSET, 14'h0111, 6'h05, 14'h0000},
    '{6'h05, REG_SEL_GAIN, 14'h0222, 6'h05, 14'h0000},
    '{6'h28, REG_SEL_DATA, 14'h3333, 6'h00, 14'h1234}};
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic if_sel = 1'b0, pd = 1'b0;
  logic ser_clk, ser_sync_n, ser_din; // chain lines, driven by the serial scenario
  logic [DAC_AW-1:0] rd_addr = '0;
  logic [ADDR_W-1:0] addr;
  logic [SEL_W-1:0] reg_sel;
  logic [DATA_W-1:0] data, dac_code_o;
  logic cs_n, wr_n, bank, load_n, clear_n, rst_pin_n;
  logic busy_o, pd_act, hiz, pd_load, toggle_mode_o, ser_dout, ser_oe_n;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  always #50 core_clk_i = ~core_clk_i;
  host_bus_model host (.core_clk_i(core_clk_i), .addr_o(addr), .reg_sel_o(reg_sel),
    .data_o(data), .cs_n_o(cs_n), .wr_n_o(wr_n), .bank_o(bank), .load_n_o(load_n),
    .clear_n_o(clear_n), .rst_pin_n_o(rst_pin_n));
  dac_channel_update_control #(.CALC_CYCLES(CALC)) uut (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .interface_select_i(if_sel), .channel_address_inputs_i(addr),
    .register_select_pins_i(reg_sel), .data_i(data), .chip_select_n_i(cs_n),
    .write_n_i(wr_n), .bank_select_i(bank), .load_outputs_strobe_n_i(load_n),
    .clear_input_n_i(clear_n), .reset_pin_n_i(rst_pin_n), .power_down_input_i(pd),
    .serial_clk_i(ser_clk), .serial_sync_n_i(ser_sync_n), .serial_data_i(ser_din),
    .dac_read_addr_i(rd_addr), .busy_o(busy_o), .dac_code_o(dac_code_o),
    .power_down_active_o(pd_act), .output_hiz_o(hiz), .output_load_o(pd_load),
    .toggle_mode_o(toggle_mode_o), .serial_data_o(ser_dout),
    .serial_data_oe_n_o(ser_oe_n));
  // verdict and end of run
  task automatic results();
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // case-equality compare of one value
  task automatic chk(input string name, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  // idle means busy high three samples running, so a queued load is not missed
  task automatic wait_idle();
    int k = 0;
    repeat (2) @(negedge core_clk_i);
    while (k < 3) begin
      @(negedge core_clk_i);
      k = (busy_o === 1'b1) ? k + 1 : 0;
    end
  endtask
  // code readback has one cycle of latency
  task automatic rd(input logic [DAC_AW-1:0] ch, input logic [DATA_W-1:0] e);
    @(posedge core_clk_i);
    rd_addr <= ch;
    repeat (2) @(negedge core_clk_i);
    chk("dac_code", e, dac_code_o);
  endtask
  // hang guard, well above the expected length
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    ser_clk <= 1'b0;
    ser_sync_n <= 1'b1;
    ser_din <= 1'b0;
    repeat (10) @(negedge core_clk_i);
    chk("busy_reset", 14'(busy_o), 14'h0000);
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (2690) @(negedge core_clk_i);
    chk("busy_walk", 14'(busy_o), 14'h0000);
    wait_idle();
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].s, rows[i].d, 1'b0);
      wait_idle();
      host.pulse(0);
      wait_idle();
      rd(rows[i].r, rows[i].e);
    end
    // load during a calc is held and done afterwards
    host.wr(6'h01, REG_SEL_DATA, 14'h0AAA, 1'b0);
    @(negedge core_clk_i);
    chk("busy_calc", 14'(busy_o), 14'h0000);
    host.pulse(0);
    rd(1, 14'h0000);
    wait_idle();
    rd(1, 14'h0AAA);
    // toggle mode: banks A and B, loads alternate starting with B
    host.wr(SF_CONTROL_ADDR, REG_SEL_SPECIAL, 14'h0001, 1'b0);
    wait_idle();
    chk("toggle_mode", 14'(toggle_mode_o), 14'h0001);
    host.wr(6'h02, REG_SEL_DATA, 14'h0100, 1'b0);
    wait_idle();
    host.wr(6'h02, REG_SEL_DATA, 14'h0200, 1'b1);
    wait_idle();
    for (int j = 0; j < 2; j++) begin
      host.pulse(0);
      wait_idle();
      rd(2, j == 0 ? 14'h0200 : 14'h0100);
    end
    host.wr(SF_CONTROL_ADDR, REG_SEL_SPECIAL, 14'h0000, 1'b0);
    wait_idle();
    host.wr(6'h02, REG_SEL_DATA, 14'h0300, 1'b1); // bank ignored
    wait_idle();
    host.pulse(0);
    wait_idle();
    rd(2, 14'h0300);
    // clear: exact busy length, channels 39 and 0 take the clear code
    host.wr(SF_CLEAR_CODE_ADDR, REG_SEL_SPECIAL, 14'h1555, 1'b0);
    wait_idle();
    host.pulse(1);
    n = 0;
    while (busy_o !== 1'b0 && n < 10) begin
      @(negedge core_clk_i);
      n++;
    end
    n = 0;
    while (busy_o === 1'b0) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("clear_busy", 14'(n), 14'h015E);
    rd(39, 14'h1555);
    rd(0, 14'h1555);
    // reset pin: loads dropped, registers back to defaults
    host.pulse(2);
    repeat (20) @(posedge core_clk_i);
    host.pulse(0);
    wait_idle();
    rd(0, 14'h0000);
    host.pulse(0);
    wait_idle();
    rd(0, 14'h0000); // input default after the walk
    // power down, high impedance then resistive option
    @(posedge core_clk_i);
    pd <= 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("pd_hiz", 14'({pd_act, hiz, pd_load}), 14'h0006);
    host.wr(SF_CONTROL_ADDR, REG_SEL_SPECIAL, 14'h0002, 1'b0);
    wait_idle();
    chk("pd_load", 14'({pd_act, hiz, pd_load}), 14'h0005);
    // serial mode with no frame open leaves the output undriven
    @(posedge core_clk_i);
    if_sel <= 1'b1; // host picks the serial side
    repeat (3) @(negedge core_clk_i);
    chk("ser_oe_n", 14'(ser_oe_n), 14'h0001);
    // chain frame: 25 ones shifted in, the next rise shows a one
    @(posedge core_clk_i);
    ser_sync_n <= 1'b0;
    ser_din <= 1'b1;
    for (int j = 0; j < 25; j++) begin
      @(posedge core_clk_i);
      ser_clk <= 1'b1;
      @(posedge core_clk_i);
      ser_clk <= 1'b0;
    end
    @(posedge core_clk_i);
    ser_clk <= 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("ser_dout", 14'(ser_dout), 14'h0001);
    chk("ser_oe_frame", 14'(ser_oe_n), 14'h0000);
    @(posedge core_clk_i);
    ser_sync_n <= 1'b1;
    ser_clk <= 1'b0;
    results();
  end
endmodule

// [verification/host_bus_model.sv]
`timescale 1ns/100ps
// host side of the parallel pins; serial lines stay with the bench
module host_bus_model import dac_ctrl_pkg::*; (
  input wire logic core_clk_i,
  output logic [ADDR_W-1:0] addr_o = '0,
  output logic [SEL_W-1:0] reg_sel_o = '0,
  output logic [DATA_W-1:0] data_o = '0,
  output logic cs_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic bank_o = 1'b0,
  output logic load_n_o = 1'b1,
  output logic clear_n_o = 1'b1,
  output logic rst_pin_n_o = 1'b1
);
  // one write; the bus is held until after the taking edge, then released
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [SEL_W-1:0] s,
                    input logic [DATA_W-1:0] d, input logic b);
    @(posedge core_clk_i);
    cs_n_o <= 1'b0;
    addr_o <= a;
    reg_sel_o <= s;
    data_o <= d;
    bank_o <= b; // bank only matters in toggle mode
    wr_n_o <= 1'b0;
    @(posedge core_clk_i);
    wr_n_o <= 1'b1; // rising edge takes the write
    @(posedge core_clk_i);
    cs_n_o <= 1'b1;
    data_o <= ~d; // released bus must not look like the old word
  endtask
  // falling-edge pulse: 0 load, 1 clear, 2 reset pin
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    if (k == 0) load_n_o <= 1'b0;
    else if (k == 1) clear_n_o <= 1'b0;
    else rst_pin_n_o <= 1'b0;
    @(posedge core_clk_i);
    load_n_o <= 1'b1;
    clear_n_o <= 1'b1;
    rst_pin_n_o <= 1'b1;
  endtask
endmodule
